// File: rtl/sacc_pkg.sv
package sacc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int clk_mhz = 100;
  localparam int clk_ns = 10;
  localparam int fast_period_ns = 1000;
  localparam int normal_period_ns = 1250;
  localparam int fast_cycles = fast_period_ns / clk_ns;
  localparam int normal_cycles = normal_period_ns / clk_ns;
  localparam int acq_cycles_fast = fast_cycles - 17;
  localparam int acq_cycles_normal = normal_cycles - 17;
  localparam int acq_cycles_low = acq_cycles_normal + 30;
  localparam int cnt_w = 8;
  // ----------------------------------------
  // data
  // ----------------------------------------
  localparam int res_bits = 16;
  localparam int msb = res_bits - 1;
  localparam logic [15:0] code_max = 16'hffff;
  localparam logic [15:0] code_min = 16'h0000;
  localparam logic [15:0] msb_mask = 16'h8000;
  // ----------------------------------------
  // axi-lite map
  // ----------------------------------------
  localparam logic [3:0] addr_ctrl = 4'h0;
  localparam logic [3:0] addr_status = 4'h4;
  localparam logic [3:0] addr_result = 4'h8;
  localparam logic [3:0] addr_count = 4'hc;
  localparam int ctrl_fast = 0;
  localparam int ctrl_low = 1;
  localparam int ctrl_coding = 2;
  localparam int ctrl_pd = 3;
  localparam logic [31:0] ctrl_reset = 32'h0000_0004;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    sacc_idle_s = 2'b00,
    sacc_acq_s = 2'b01,
    sacc_conv_s = 2'b10,
    sacc_done_s = 2'b11
  } sacc_state_t;
endpackage

// File: rtl/sacc_top.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - start falling edge holds sample, starts conversion
// - sixteen steps, msb first to lsb
// - code formed, then busy falls
// - result belongs to conversion just finished
// - three modes: fast, normal, low-power
// - fast mode up to 1 MSPS
// - normal mode 800 kSPS, no gap limit
// - coding select picks binary or twos complement
// - twos complement is binary, msb inverted
// - over-range saturates to full-scale code
// - under-range saturates to minimum code
// - low-power: start held low converts at acq end
// - aresetn low, or a soft reset (ctrl bit 4 written), aborts conversion
// - power-down finishes current, blocks new starts
module sacc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conversion_start_n,
  input wire logic comparator_high,
  input wire logic over_range,
  input wire logic under_range,
  output logic busy,
  output logic hold_sample,
  output logic [15:0] dac_code,
  output logic [15:0] result,
  output logic result_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [15:0] conv_count;
  logic [31:0] next_ctrl;
  logic aw_hold, w_hold;
  logic [3:0] aw_addr;
  logic aw_hi;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic mode_fast, mode_low, coding_bin, pd_req, soft_reset;

  assign mode_fast = ctrl[sacc_pkg::ctrl_fast];
  assign mode_low = ctrl[sacc_pkg::ctrl_low] & ~ctrl[sacc_pkg::ctrl_fast];
  assign coding_bin = ctrl[sacc_pkg::ctrl_coding];
  assign pd_req = ctrl[sacc_pkg::ctrl_pd];
  assign soft_reset = aw_hold & w_hold & ~s_axi_bvalid & (aw_addr == sacc_pkg::addr_ctrl) & ~aw_hi
                      & w_strb[0] & w_data[4];

  always_comb begin
    next_ctrl = ctrl;
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        next_ctrl[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
    next_ctrl[31:4] = '0;
  end

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      aw_hi <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sacc_pkg::resp_okay;
      ctrl <= sacc_pkg::ctrl_reset;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_hold & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr[3:0];
        // only the low nibble is decoded, so any upper bit marks a miss
        aw_hi <= |s_axi_awaddr[31:4];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == sacc_pkg::addr_ctrl && !aw_hi) begin
          ctrl <= next_ctrl;
          s_axi_bresp <= sacc_pkg::resp_okay;
        end else begin
          s_axi_bresp <= sacc_pkg::resp_slverr;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  sacc_pkg::sacc_state_t state;
  logic start_d;
  logic start_fall;
  logic [sacc_pkg::cnt_w-1:0] acq_cnt;
  logic [sacc_pkg::cnt_w-1:0] acq_len;
  logic [3:0] bit_idx;
  logic [15:0] trial;
  logic [15:0] bin_code;
  logic [15:0] next_trial;

  assign start_fall = start_d & ~conversion_start_n;
  // acq_len is shortest in fast mode, but only the low-power start waits for it; low-power idles longer
  assign acq_len = mode_fast ? sacc_pkg::cnt_w'(sacc_pkg::acq_cycles_fast) :
                   mode_low ? sacc_pkg::cnt_w'(sacc_pkg::acq_cycles_low) :
                   sacc_pkg::cnt_w'(sacc_pkg::acq_cycles_normal);

  // per bit: the bit under test keeps the comparator's verdict, the next lower bit is tried
  for (genvar k = 0; k < sacc_pkg::res_bits; k++) begin : g_step
    assign next_trial[k] = (k == int'(bit_idx)) ? (trial[k] & comparator_high) :
                           ((k + 1 == int'(bit_idx)) ? 1'b1 : trial[k]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      start_d <= 1'b1;
    end else begin
      start_d <= conversion_start_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      state <= sacc_pkg::sacc_idle_s;
      acq_cnt <= '0;
      bit_idx <= '0;
      trial <= '0;
      bin_code <= '0;
      busy <= 1'b0;
      hold_sample <= 1'b0;
      dac_code <= '0;
    end else begin
      unique case (state)
        sacc_pkg::sacc_idle_s: begin
          // power-down only blocks new starts; a running conversion is never cut short
          if ((start_fall || (mode_low && !conversion_start_n && acq_cnt == acq_len))
              && !pd_req) begin
            state <= sacc_pkg::sacc_conv_s;
            busy <= 1'b1;
            hold_sample <= 1'b1;
            bit_idx <= 4'(sacc_pkg::msb);
            trial <= sacc_pkg::msb_mask;
            dac_code <= sacc_pkg::msb_mask;
          end else if (acq_cnt != acq_len) begin
            acq_cnt <= acq_cnt + 1'b1;
          end
        end
        sacc_pkg::sacc_conv_s: begin
          // start edges fall here unseen, so a busy conversion runs on
          trial <= next_trial;
          dac_code <= next_trial;
          if (bit_idx == 4'h0) begin
            state <= sacc_pkg::sacc_done_s;
            bin_code <= over_range ? sacc_pkg::code_max :
                        under_range ? sacc_pkg::code_min : next_trial;
          end else begin
            bit_idx <= bit_idx - 4'h1;
          end
        end
        sacc_pkg::sacc_done_s: begin
          busy <= 1'b0;
          hold_sample <= 1'b0;
          acq_cnt <= '0;
          state <= sacc_pkg::sacc_idle_s;
        end
        default: begin
          state <= sacc_pkg::sacc_idle_s;
        end
      endcase
    end
  end

  // ----------------------------------------
  // result register
  // ----------------------------------------
  // soft reset only aborts the sequencer; the last word and the count survive it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
      result_valid <= 1'b0;
      conv_count <= '0;
    end else begin
      result_valid <= 1'b0;
      if (state == sacc_pkg::sacc_done_s && !soft_reset) begin
        // coded word lands together with busy falling, from this sample only
        result <= coding_bin ? bin_code : (bin_code ^ sacc_pkg::msb_mask);
        result_valid <= 1'b1;
        conv_count <= conv_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sacc_pkg::resp_okay;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sacc_pkg::resp_okay;
        // only the low nibble is decoded, so any upper bit marks a miss
        if (|s_axi_araddr[31:4]) begin
          s_axi_rdata <= '0;
          s_axi_rresp <= sacc_pkg::resp_slverr;
        end else begin
          unique case (s_axi_araddr[3:0])
            sacc_pkg::addr_ctrl: s_axi_rdata <= ctrl;
            sacc_pkg::addr_status: s_axi_rdata <= {28'h0000000, state == sacc_pkg::sacc_idle_s,
                                                    pd_req, hold_sample, busy};
            sacc_pkg::addr_result: s_axi_rdata <= {16'h0000, result};
            sacc_pkg::addr_count: s_axi_rdata <= {16'h0000, conv_count};
            default: begin
              s_axi_rdata <= '0;
              s_axi_rresp <= sacc_pkg::resp_slverr;
            end
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sacc_top

// File: testbench/sacc_checker_assertions.sv
`timescale 1ns/1ps
// ----
// conversion and read-channel checks
// ----
module sacc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic busy,
  input wire logic hold_sample,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] result,
  input wire logic result_valid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_go; $rose(busy); endsequence
  sequence s_run; busy[*8] ##1 busy[*8] ##1 !busy; endsequence
  property p_start; s_go |-> hold_sample && dac_code == 16'h8000; endproperty
  a_start: assert property (p_start) else $error("first trial wrong");
  property p_msb; s_go |=> dac_code[14:0] == 15'h4000; endproperty
  a_msb: assert property (p_msb) else $error("second trial wrong");
  property p_len; s_go |=> s_run; endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_valid; result_valid |-> $fell(busy); endproperty
  a_valid: assert property (p_valid) else $error("valid without busy fall");
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  // reset clears the result, so the cycle after reset is exempt
  property p_keep; !result_valid && $past(aresetn) |-> $stable(result); endproperty
  a_keep: assert property (p_keep) else $error("result moved");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_r; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r: assert property (p_r) else $error("read answer stuck");
endmodule // sacc_checker
bind sacc_top sacc_checker chk (.*);

// File: testbench/sacc_host_model.sv
`timescale 1ns/1ps
// ----
// host start pin and ideal comparator
// ----
module sacc_host_model (
  input wire logic aclk,
  input wire logic req,
  input wire logic [15:0] target,
  input wire logic ovr,
  input wire logic und,
  input wire logic [15:0] dac_code,
  output logic conversion_start_n,
  output logic comparator_high,
  output logic over_range,
  output logic under_range
);
  // start is launched off the edge, like a registered host pin; runs stay short
  // every result is compared, none discarded: the ideal comparator has no warm-up
  initial begin
    conversion_start_n = 1'b1;
    forever @(posedge aclk) conversion_start_n <= !req;
  end
  assign comparator_high = target >= dac_code;
  assign over_range = ovr;
  assign under_range = und;
endmodule // sacc_host_model

// File: testbench/sacc_top_test.sv
`timescale 1ns/1ps
// ----
// bench
// ----
module sacc_top_test;
  logic aclk, aresetn, req, ovr, und, conversion_start_n, comparator_high, over_range, under_range;
  logic busy, hold_sample, result_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] target, dac_code, result;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat, c0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] tv [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h1234};
  logic [31:0] md [3] = '{32'h5, 32'h4, 32'h6};
  int miscompares = 0;
  int check_count = 0;
  sacc_top dut (.*);
  sacc_host_model host (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    chk(s_axi_rresp, e);
  endtask
  task automatic wt(input logic [15:0] x);
    int n = 0;
    do begin @(posedge aclk); n++; end while (result_valid !== 1'b1 && n < 200);
    chk(result_valid, 1'b1);
    chk(result, x);
  endtask
  // one start pulse; expected code worked out from clamp and coding
  task automatic cv(input logic [15:0] t, input logic o, u, c);
    logic [15:0] x;
    x = o ? 16'hffff : (u ? 16'h0000 : t);
    x = c ? x : x ^ 16'h8000;
    target <= t;
    ovr <= o;
    und <= u;
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    wt(x);
    rd(32'h8, 2'h0);
    chk(rdat, {16'h0, x});
  endtask
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  initial begin
    {aresetn, req, ovr, und, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {target, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(32'h0, 2'h0);
    chk(rdat, 32'h4);
    rd(32'h10, 2'h2);
    wr(32'h4, 32'h1, 2'h2);
    wr(32'h10, 32'h1, 2'h2);
    wr(32'h0, 32'h14, 2'h0);
    rd(32'h0, 2'h0);
    chk(rdat, 32'h4);
    $display("map done");
    for (int c = 1; c >= 0; c--) begin
      wr(32'h0, c ? 32'h4 : 32'h0, 2'h0);
      foreach (tv[i]) cv(tv[i], 1'b0, 1'b0, c[0]);
      cv(16'h5555, 1'b1, 1'b0, c[0]);
      cv(16'h5555, 1'b0, 1'b1, c[0]);
    end
    $display("coding done");
    foreach (md[i]) begin
      wr(32'h0, md[i], 2'h0);
      cv(16'h0f0f, 1'b0, 1'b0, 1'b1);
      cv(16'hf0f0, 1'b0, 1'b0, 1'b1);
    end
    $display("modes done");
    wr(32'h0, 32'h4, 2'h0);
    rd(32'hc, 2'h0);
    c0 = rdat;
    fork
      cv(16'h4321, 1'b0, 1'b0, 1'b1);
      begin repeat (6) @(posedge aclk); req <= 1'b1; @(posedge aclk); req <= 1'b0; end
    join
    fork
      cv(16'h2222, 1'b0, 1'b0, 1'b1);
      begin repeat (4) @(posedge aclk); wr(32'h0, 32'hc, 2'h0); end
    join
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(busy, 1'b0);
    rd(32'hc, 2'h0);
    chk(rdat, c0 + 32'h2);
    $display("busy and power-down done");
    wr(32'h0, 32'h6, 2'h0);
    target <= 16'h0abc;
    req <= 1'b1;
    wt(16'h0abc);
    wt(16'h0abc);
    req <= 1'b0;
    $display("low power done");
    repeat (3) @(posedge aclk);
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(busy, 1'b0);
    chk(result, 16'h0);
    $display("reset done");
    finish_test;
  end
endmodule // sacc_top_test
